// ---- core/ecs_regs.svh ----
`ifndef ECS_REGS_SVH
`define ECS_REGS_SVH
// ****************************************************************
// Link frame layout
// ****************************************************************
`define ECS_CMD_BITS       40
`define ECS_RSP_BITS       11
`define ECS_RSP_LAST       4'hA
`define ECS_RX_LAST        6'h26
`define ECS_WAIT_LIMIT     6'h10
`define ECS_CMD_SWITCH     6'h06
`define ECS_CMD_READ_BYTE  6'h08
`define ECS_CMD_BLOCK_CNT  6'h17
// ****************************************************************
// Configuration array byte indices
// ****************************************************************
`define ECS_IDX_DRAIN      8'h20
`define ECS_IDX_SWITCH     8'h21
`define ECS_IDX_CTX_LO     8'h25
`define ECS_IDX_CTX_HI     8'h33
`define ECS_IDX_EXTATTR_LO 8'h34
`define ECS_IDX_EXTATTR_HI 8'h35
`define ECS_IDX_EVT_LO     8'h38
`define ECS_IDX_EVT_HI     8'h39
`define ECS_IDX_CLASS6     8'h3B
`define ECS_IDX_VEND_LO    8'h40
`define ECS_IDX_VEND_HI    8'h7F
`define ECS_IDX_WAKE       8'h83
`define ECS_IDX_TCASE      8'h84
`define ECS_IDX_ENH_LO     8'h8C
`define ECS_IDX_GP_LO      8'h8F
`define ECS_IDX_PART_DONE  8'h9B
`define ECS_IDX_MAXENH     8'h9D
`define ECS_IDX_TIMING     8'hB9
`define ECS_IDX_POWER      8'hBB
`define ECS_IDX_REV        8'hC0
`define ECS_IDX_DRV_STR    8'hC5
`define ECS_IDX_WP_GRP     8'hDD
`define ECS_IDX_ERASE_GRP  8'hE0
`define ECS_IDX_SEC_TRIM   8'hE5
`define ECS_IDX_SEC_ERASE  8'hE6
`define ECS_IDX_SEC_FEAT   8'hE7
// ****************************************************************
// Fixed array contents
// ****************************************************************
`define ECS_VAL_REV        8'h06
`define ECS_VAL_SEC_ERASE  8'h02
`define ECS_VAL_SEC_TRIM   8'h0A
`define ECS_VAL_SEC_FEAT   8'h55
`define ECS_VAL_ERASE_GRP  8'h08
`define ECS_VAL_WP_GRP     8'h02
`define ECS_VAL_MAXENH     24'h0001D2
`define ECS_VAL_DRV_STR    8'h0F
`define ECS_ENH_UNIT_KB    10'h200
`define ECS_DRV_LSB        4
// ****************************************************************
// Host register offsets and status bits
// ****************************************************************
`define ECS_HREG_CMD       4'h0
`define ECS_HREG_ARG       4'h4
`define ECS_HREG_CTRL      4'h8
`define ECS_HREG_RESP      4'hC
`define ECS_ST_BUSY        0
`define ECS_ST_DONE        1
`define ECS_ST_ERR         2
`define ECS_ST_REFUSED     3
`endif

// ---- core/ecs_pkg.sv ----
package ecs_pkg;
   typedef enum logic [1:0] {
      D_IDLE = 2'b00,
      D_RECV = 2'b01,
      D_TURN = 2'b10,
      D_RESP = 2'b11
   } ecs_dev_state_type;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SEND = 2'b01,
      H_WAIT = 2'b10,
      H_RECV = 2'b11
   } ecs_host_state_type;

   typedef logic [255:0][7:0] ecs_array_type;
endpackage

// ---- core/ecs_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface ecs_link_if;
   logic link_clk;
   logic host_cmd_o;
   logic host_cmd_oe_n;
   logic dev_cmd_o;
   logic dev_cmd_oe_n;
   logic cmd;

   // Pulled-up shared command line
   assign cmd = !host_cmd_oe_n ? host_cmd_o :
                !dev_cmd_oe_n  ? dev_cmd_o  : 1'b1;

   modport host (output link_clk, output host_cmd_o,
                 output host_cmd_oe_n, input cmd);
   modport device (input link_clk, output dev_cmd_o,
                   output dev_cmd_oe_n, input cmd);
endinterface
`default_nettype wire

// ---- core/ecs_device.sv ----
// Added by the designer: the strobed register port, in ecs_host.
`timescale 1ns/1ns
`default_nettype none
`include "ecs_regs.svh"
module ecs_device
   import ecs_pkg::*;
(
   // Reset
   input  wire logic  rst_n,
   // Link
   ecs_link_if.device link,
   // User side
   output logic [1:0]  drive_type,
   output logic [15:0] block_count,
   output logic        partition_done,
   output logic [33:0] enhanced_limit_kb
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      ecs_dev_state_type state;
      logic [5:0]        cnt;
      logic [37:0]       sh;
      logic [10:0]       rsp;
      logic              cmd_o;
      logic              cmd_oe_n;
      logic [1:0]        drv;
      logic [15:0]       blocks;
      logic              part_done;
      logic [33:0]       lim;
      ecs_array_type     arr;
   } ecs_dev_type;

   ecs_dev_type q;
   ecs_dev_type d;

   // ****************************************************************
   // Array helpers
   // ****************************************************************
   localparam logic [23:0] MAX_ENH      = `ECS_VAL_MAXENH;
   // Constant product, registered so the output comes from a flop
   localparam logic [33:0] ENH_LIMIT_KB = 34'(`ECS_VAL_MAXENH)
      * 34'(`ECS_VAL_WP_GRP) * 34'(`ECS_VAL_ERASE_GRP)
      * 34'(`ECS_ENH_UNIT_KB);

   function automatic logic in_rng(input logic [7:0] i,
                                   input logic [7:0] lo,
                                   input logic [7:0] hi);
      in_rng = (i >= lo) && (i <= hi);
   endfunction

   // Write-only cells read back as zero
   function automatic logic write_only(input logic [7:0] i);
      write_only = (i == `ECS_IDX_DRAIN) || (i == `ECS_IDX_TCASE);
   endfunction

   function automatic logic writable(input logic [7:0] i);
      writable = write_only(i) || (i == `ECS_IDX_SWITCH)
         || in_rng(i, `ECS_IDX_CTX_LO, `ECS_IDX_CTX_HI)
         || in_rng(i, `ECS_IDX_EXTATTR_LO, `ECS_IDX_EXTATTR_HI)
         || in_rng(i, `ECS_IDX_EVT_LO, `ECS_IDX_EVT_HI)
         || (i == `ECS_IDX_CLASS6) || (i == `ECS_IDX_WAKE)
         || in_rng(i, `ECS_IDX_ENH_LO, `ECS_IDX_PART_DONE)
         || (i == `ECS_IDX_TIMING) || (i == `ECS_IDX_POWER);
   endfunction

   function automatic logic [7:0] fixed_byte(input logic [7:0] i);
      case (i)
         `ECS_IDX_REV:       fixed_byte = `ECS_VAL_REV;
         `ECS_IDX_SEC_ERASE: fixed_byte = `ECS_VAL_SEC_ERASE;
         `ECS_IDX_SEC_TRIM:  fixed_byte = `ECS_VAL_SEC_TRIM;
         `ECS_IDX_SEC_FEAT:  fixed_byte = `ECS_VAL_SEC_FEAT;
         `ECS_IDX_ERASE_GRP: fixed_byte = `ECS_VAL_ERASE_GRP;
         `ECS_IDX_WP_GRP:    fixed_byte = `ECS_VAL_WP_GRP;
         `ECS_IDX_DRV_STR:   fixed_byte = `ECS_VAL_DRV_STR;
         `ECS_IDX_MAXENH:    fixed_byte = MAX_ENH[7:0];
         `ECS_IDX_MAXENH + 8'h01: fixed_byte = MAX_ENH[15:8];
         `ECS_IDX_MAXENH + 8'h02: fixed_byte = MAX_ENH[23:16];
         default:            fixed_byte = 8'h00;
      endcase
   endfunction

   function automatic logic [23:0] mult3(input ecs_array_type a,
                                         input logic [7:0]    b);
      mult3 = {a[b + 8'h02], a[b + 8'h01], a[b]};
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   logic [5:0]  f_idx;
   logic [31:0] f_arg;
   logic [7:0]  f_sel;
   logic [7:0]  f_data;
   logic        f_err;
   logic [26:0] f_sum;

   always_comb begin
      d      = q;
      d.lim  = ENH_LIMIT_KB;
      f_idx  = q.sh[37:32];
      f_arg  = q.sh[31:0];
      f_sel  = f_arg[23:16];
      f_data = 8'h00;
      f_err  = 1'b0;
      f_sum  = 27'h0;
      case (q.state)
         D_IDLE: begin
            d.cmd_oe_n = 1'b1;
            if (!link.cmd) begin
               d.state = D_RECV;
               d.cnt   = 6'h00;
            end
         end
         D_RECV: begin
            if (q.cnt == `ECS_RX_LAST) begin
               // Last bit is the end bit and is not kept
               d.state = D_TURN;
               f_err   = !link.cmd;
               case (f_idx)
                  `ECS_CMD_SWITCH: begin
                     if (f_sel == `ECS_IDX_PART_DONE && f_arg[8]) begin
                        f_sum = 27'(mult3(q.arr, `ECS_IDX_ENH_LO));
                        for (int g = 0; g < 4; g++) begin
                           f_sum = f_sum + 27'(mult3(q.arr,
                              8'(`ECS_IDX_GP_LO + 3 * g)));
                        end
                        if (f_sum > 27'(`ECS_VAL_MAXENH)) begin
                           f_err = 1'b1;
                        end
                     end
                     // Inert cells take the value silently
                     if (writable(f_sel) && !f_err) begin
                        d.arr[f_sel] = f_arg[15:8];
                        if (f_sel == `ECS_IDX_TIMING) begin
                           d.drv = d.arr[f_sel][`ECS_DRV_LSB +: 2];
                        end
                        if (f_sel == `ECS_IDX_PART_DONE) begin
                           d.part_done = f_arg[8];
                        end
                     end
                     f_data = f_arg[15:8];
                  end
                  `ECS_CMD_READ_BYTE: begin
                     if (!writable(f_sel)) begin
                        f_data = fixed_byte(f_sel);
                     end else if (!write_only(f_sel)) begin
                        f_data = q.arr[f_sel];
                     end
                  end
                  `ECS_CMD_BLOCK_CNT: begin
                     d.blocks = f_arg[15:0];
                  end
                  default: f_err = 1'b1;
               endcase
               d.rsp = {1'b0, f_err, f_data, 1'b1};
            end else begin
               d.sh  = {q.sh[36:0], link.cmd};
               d.cnt = q.cnt + 6'h01;
            end
         end
         D_TURN: begin
            d.state    = D_RESP;
            d.cnt      = 6'h00;
            d.cmd_oe_n = 1'b0;
            d.cmd_o    = q.rsp[10];
            d.rsp      = {q.rsp[9:0], 1'b1};
         end
         D_RESP: begin
            if (q.cnt[3:0] == `ECS_RSP_LAST) begin
               d.state    = D_IDLE;
               d.cmd_oe_n = 1'b1;
               d.cmd_o    = 1'b1;
            end else begin
               d.cmd_o = q.rsp[10];
               d.rsp   = {q.rsp[9:0], 1'b1};
               d.cnt   = q.cnt + 6'h01;
            end
         end
         default: d.state = D_IDLE;
      endcase
   end

   // Capture on the rising edge of the link clock
   always_ff @(posedge link.link_clk or negedge rst_n) begin
      if (!rst_n) begin
         q          <= '0;
         q.state    <= D_IDLE;
         q.cmd_o    <= 1'b1;
         q.cmd_oe_n <= 1'b1;
         q.rsp      <= 11'h7FF;
         q.drv      <= 2'h0;
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign link.dev_cmd_o    = q.cmd_o;
   assign link.dev_cmd_oe_n = q.cmd_oe_n;
   assign drive_type        = q.drv;
   assign block_count       = q.blocks;
   assign partition_done    = q.part_done;
   assign enhanced_limit_kb = q.lim;
endmodule
`default_nettype wire

// ---- core/ecs_host.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ecs_regs.svh"
module ecs_host
   import ecs_pkg::*;
#(
   parameter int HALF = 4
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata,
   // Link
   ecs_link_if.host         link
);
   localparam logic [7:0] DIV_FALL = 8'(HALF - 1);
   localparam logic [7:0] DIV_LAST = 8'(2 * HALF - 1);

   typedef struct packed {
      ecs_host_state_type state;
      logic [7:0]         div;
      logic               link_clk;
      logic               sync1;
      logic               sync2;
      logic [5:0]         cnt;
      logic [39:0]        sh;
      logic [9:0]         rx;
      logic               cmd_o;
      logic               cmd_oe_n;
      logic [5:0]         idx;
      logic [31:0]        arg;
      logic               done;
      logic               err;
      logic               refused;
      logic [7:0]         resp;
      logic [31:0]        rdata;
   } ecs_host_type;

   ecs_host_type q;
   ecs_host_type d;

   logic fall_tick;
   logic rise_tick;
   logic go;
   logic private_hit;

   always_comb begin
      d           = q;
      fall_tick   = (q.div == DIV_FALL);
      rise_tick   = (q.div == DIV_LAST);
      go          = wr && (addr == `ECS_HREG_CTRL) && wdata[0];
      private_hit = (q.idx == `ECS_CMD_SWITCH
                     || q.idx == `ECS_CMD_READ_BYTE)
                  && q.arg[23:16] >= `ECS_IDX_VEND_LO
                  && q.arg[23:16] <= `ECS_IDX_VEND_HI;
      d.div      = rise_tick ? 8'h00 : q.div + 8'h01;
      d.link_clk = (d.div < 8'(HALF));
      d.sync1    = link.cmd;
      d.sync2    = q.sync1;
      if (wr && addr == `ECS_HREG_CMD && q.state == H_IDLE) begin
         d.idx = wdata[5:0];
      end
      if (wr && addr == `ECS_HREG_ARG && q.state == H_IDLE) begin
         d.arg = wdata;
      end
      case (addr)
         `ECS_HREG_CMD:  d.rdata = {26'h0, q.idx};
         `ECS_HREG_ARG:  d.rdata = q.arg;
         `ECS_HREG_CTRL: d.rdata = {28'h0, q.refused, q.err, q.done,
                                    q.state != H_IDLE};
         `ECS_HREG_RESP: d.rdata = {24'h0, q.resp};
         default:        d.rdata = 32'h0;
      endcase
      if (!rd) begin
         d.rdata = 32'h0;
      end
      case (q.state)
         H_IDLE: begin
            if (go) begin
               d.done    = 1'b0;
               d.err     = 1'b0;
               d.refused = private_hit;
               if (private_hit) begin
                  d.done = 1'b1;
               end else begin
                  d.state = H_SEND;
                  d.cnt   = 6'h00;
                  d.sh    = {1'b0, q.idx, q.arg, 1'b1};
               end
            end
         end
         H_SEND: begin
            // Bits change on the falling edge, stable at the rise
            if (fall_tick) begin
               if (q.cnt == 6'(`ECS_CMD_BITS)) begin
                  d.cmd_oe_n = 1'b1;
                  d.cmd_o    = 1'b1;
                  d.state    = H_WAIT;
                  d.cnt      = 6'h00;
               end else begin
                  d.cmd_oe_n = 1'b0;
                  d.cmd_o    = q.sh[39];
                  d.sh       = {q.sh[38:0], 1'b1};
                  d.cnt      = q.cnt + 6'h01;
               end
            end
         end
         H_WAIT: begin
            if (rise_tick) begin
               if (!q.sync2) begin
                  d.state = H_RECV;
                  d.cnt   = 6'h00;
               end else if (q.cnt == `ECS_WAIT_LIMIT) begin
                  d.state = H_IDLE;
                  d.err   = 1'b1;
                  d.done  = 1'b1;
               end else begin
                  d.cnt = q.cnt + 6'h01;
               end
            end
         end
         H_RECV: begin
            if (rise_tick) begin
               d.rx  = {q.rx[8:0], q.sync2};
               d.cnt = q.cnt + 6'h01;
               if (q.cnt == 6'(`ECS_RSP_BITS - 2)) begin
                  d.state = H_IDLE;
                  d.done  = 1'b1;
                  d.resp  = q.rx[7:0];
                  // Device flag covers enhanced area overflow
                  d.err   = q.rx[8] | !q.sync2;
               end
            end
         end
         default: d.state = H_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q          <= '0;
         q.state    <= H_IDLE;
         q.sync1    <= 1'b1;
         q.sync2    <= 1'b1;
         q.cmd_o    <= 1'b1;
         q.cmd_oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign rdata              = q.rdata;
   assign link.link_clk      = q.link_clk;
   assign link.host_cmd_o    = q.cmd_o;
   assign link.host_cmd_oe_n = q.cmd_oe_n;
endmodule
`default_nettype wire

// ---- tb/ecs_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module ecs_monitor (
   // Link domain
   input wire logic link_clk,
   input wire logic rst_n,
   // Command line
   input wire logic host_cmd_o,
   input wire logic host_cmd_oe_n,
   input wire logic dev_cmd_o,
   input wire logic dev_cmd_oe_n,
   input wire logic cmd
);
   // ****************************************************************
   // Command line checks
   // ****************************************************************
   default clocking cb @(posedge link_clk);
   endclocking
   default disable iff (!rst_n);

   // Eleven-bit answer: end bit high, then released
   sequence resp_tail;
      ##10 (!dev_cmd_oe_n && dev_cmd_o) ##1 dev_cmd_oe_n;
   endsequence

   a_one_driver: assert property (!(!host_cmd_oe_n && !dev_cmd_oe_n))
      else $error("both ends drive the command line");
   a_frame_start: assert property ($fell(host_cmd_oe_n) |->
      !cmd && !host_cmd_o)
      else $error("command frame lacks a low start bit");
   a_frame_end: assert property ($fell(host_cmd_oe_n) |->
      ##39 (!host_cmd_oe_n && cmd) ##1 host_cmd_oe_n)
      else $error("command frame is not forty bits with end bit");
   a_device_quiet: assert property ($fell(host_cmd_oe_n) |->
      dev_cmd_oe_n throughout (##40 1'b1))
      else $error("device drives during a command frame");
   a_answer_delay: assert property ($rose(host_cmd_oe_n) |->
      dev_cmd_oe_n ##[1:2] !dev_cmd_oe_n)
      else $error("answer does not start in time");
   a_resp_start: assert property ($fell(dev_cmd_oe_n) |-> !dev_cmd_o)
      else $error("answer lacks a low start bit");
   a_resp_length: assert property ($fell(dev_cmd_oe_n) |-> resp_tail)
      else $error("answer is not eleven bits with end bit");
   a_resp_cause: assert property ($fell(dev_cmd_oe_n) |->
      host_cmd_oe_n && $past(host_cmd_oe_n))
      else $error("answer starts without a finished command");

   c_frame: cover property ($fell(host_cmd_oe_n));
   c_resp: cover property ($fell(dev_cmd_oe_n));
   c_err: cover property ($fell(dev_cmd_oe_n) ##1 dev_cmd_o);
endmodule
`default_nettype wire

// ---- tb/extended_config_array_unsupported_field_handling_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ecs_regs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
   failures++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module extended_config_array_unsupported_field_handling_test;
   import ecs_pkg::*;
   logic        clk, rst_n, dev_rst_n, wr, rd, rd_err, partition_done;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, arg;
   logic [7:0]  rd_data, v;
   logic        rd_refused;
   logic [1:0]  drive_type;
   logic [15:0] block_count;
   logic [33:0] enhanced_limit_kb;
   int          failures, check_count, seed, k, lim, mult, mdl[256];
   int          inert[$] = '{32, 33, 37, 45, 51, 52, 53, 59, 131, 132, 187};

   ecs_link_if link_bus ();
   ecs_host #(.HALF(4)) ecs_host_inst (.clk(clk), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .link(link_bus));
   ecs_device ecs_device_inst (.rst_n(dev_rst_n), .link(link_bus),
      .drive_type(drive_type), .block_count(block_count),
      .partition_done(partition_done),
      .enhanced_limit_kb(enhanced_limit_kb));
   ecs_monitor ecs_monitor_inst (.link_clk(link_bus.link_clk),
      .rst_n(dev_rst_n), .host_cmd_o(link_bus.host_cmd_o),
      .host_cmd_oe_n(link_bus.host_cmd_oe_n),
      .dev_cmd_o(link_bus.dev_cmd_o),
      .dev_cmd_oe_n(link_bus.dev_cmd_oe_n), .cmd(link_bus.cmd));

   always #25 clk = ~clk;

   // ****************************************************************
   // Register port and command tasks
   // ****************************************************************
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic end_sim;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic run_cmd(input logic [5:0] idx, input logic [31:0] a);
      logic [31:0] st;
      int          n;
      n = 0;
      wreg(`ECS_HREG_CMD, {26'h0, idx});
      wreg(`ECS_HREG_ARG, a);
      wreg(`ECS_HREG_CTRL, 32'h1);
      do begin
         rreg(`ECS_HREG_CTRL, st);
         n++;
      end while (st[`ECS_ST_DONE] !== 1'b1 && n < 400);
      if (st[`ECS_ST_DONE] !== 1'b1) begin
         failures++;
         end_sim();
      end
      rd_err = st[`ECS_ST_ERR];
      rd_refused = st[`ECS_ST_REFUSED];
      rreg(`ECS_HREG_RESP, st);
      rd_data = st[7:0];
   endtask

   // Model view of a byte: write-only bytes read back as zero
   function automatic logic [7:0] mread(int x);
      return (x == 32 || x == 132) ? 8'h00 : 8'(mdl[x]);
   endfunction

   task automatic wbyte(input int idx, input logic [7:0] val);
      run_cmd(`ECS_CMD_SWITCH, {8'h00, 8'(idx), val, 8'h00});
      if (idx inside {[32:33], [37:53], [56:57], 59, [131:132],
                      [140:154], 185, 187})
         mdl[idx] = val;
   endtask

   task automatic chk_byte(input int idx);
      run_cmd(`ECS_CMD_READ_BYTE, {8'h00, 8'(idx), 16'h0000});
      `CHK("read_err", 1'b0, rd_err)
      `CHK("not_refused", 1'b0, rd_refused)
      `CHK("byte", mread(idx), rd_data)
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      dev_rst_n = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      seed = 32'h4a19;
      foreach (mdl[i]) mdl[i] = 0;
      mdl[192] = 8'h06;
      mdl[230] = 8'h02;
      mdl[229] = 8'h0A;
      mdl[231] = 8'h55;
      mdl[197] = 8'h0F;
      mdl[157] = 8'hD2;
      mdl[158] = 8'h01;
      mdl[221] = 8'h02;
      mdl[224] = 8'h08;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      // Device reset spans link clock start-up
      repeat (20) @(posedge clk);
      dev_rst_n <= 1'b1;
      `CHK("drive_type", 2'd0, drive_type)
      chk_byte(192);
      chk_byte(230);
      chk_byte(229);
      chk_byte(231);
      `CHK("secure_bits", 2'b11, {rd_data[4], rd_data[0]})
      chk_byte(197);
      // Host keeps off the maker private area, no frame is sent
      v = `ECS_IDX_VEND_LO | (8'($random(seed)) & 8'h3F);
      run_cmd(`ECS_CMD_READ_BYTE, {8'h00, v, 16'h0000});
      `CHK("refused", 1'b1, rd_refused)
      run_cmd(`ECS_CMD_SWITCH, {8'h00, v, 8'hA5, 8'h00});
      `CHK("refused", 1'b1, rd_refused)
      foreach (inert[j]) begin
         v = 8'($random(seed));
         wbyte(inert[j], v);
         `CHK("switch_err", 1'b0, rd_err)
         chk_byte(inert[j]);
      end
      `CHK("drive_type", 2'd0, drive_type)
      wbyte(56, 8'h0C);
      `CHK("event_err", 1'b0, rd_err)
      chk_byte(56);
      for (k = 0; k < 4; k++) begin
         arg = $random(seed);
         arg[29:24] = 6'h3F >> k;
         run_cmd(`ECS_CMD_BLOCK_CNT, arg);
         `CHK("count_err", 1'b0, rd_err)
         `CHK("block_count", arg[15:0], block_count)
      end
      for (k = 3; k >= 0; k--) begin
         wbyte(185, 8'(k << 4));
         `CHK("drive_type", 2'(k), drive_type)
      end
      mult = mdl[157] + (mdl[158] << 8) + (mdl[159] << 16);
      lim = mult * mdl[221] * mdl[224] * 512;
      `CHK("enh_limit", 34'(lim), enhanced_limit_kb)
      // One unit over the limit is refused, the exact limit accepted
      wbyte(140, 8'(mult + 1));
      wbyte(141, 8'((mult + 1) >> 8));
      wbyte(155, 8'h01);
      `CHK("over_err", 1'b1, rd_err)
      `CHK("part_done", 1'b0, partition_done)
      wbyte(140, 8'(mult - 1));
      wbyte(141, 8'((mult - 1) >> 8));
      wbyte(143, 8'h01);
      wbyte(155, 8'h01);
      `CHK("fit_err", 1'b0, rd_err)
      `CHK("part_done", 1'b1, partition_done)
      run_cmd(6'h3E, 32'h0);
      `CHK("unknown_err", 1'b1, rd_err)
      end_sim();
   end
endmodule
`default_nettype wire
